// [common/adc_ctrl_defs.svh]
// shared constants: timing, frame layout and control word fields
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ********************
// timing
// ********************
`define CLK_PERIOD_NS 10
`define PIN_PULSE_NS 100
`define PIN_PULSE_CYC ((`PIN_PULSE_NS) / (`CLK_PERIOD_NS))
`define IFACE_READY_US 500
`define IFACE_READY_CYC ((`IFACE_READY_US) * 1000 / (`CLK_PERIOD_NS))
`define REF_SETTLE_MS 6
`define REF_SETTLE_CYC ((`REF_SETTLE_MS) * 1000000 / (`CLK_PERIOD_NS))
`define WAKE_US 1
`define WAKE_CYC ((`WAKE_US) * 1000 / (`CLK_PERIOD_NS))

// ********************
// serial frame
// ********************
`define FRAME_BITS 16
`define FRAME_LAST 15
`define TRACK_EDGE 14
`define NUM_CHANS 8

// ********************
// control word fields
// ********************
`define CR_WRITE 15
`define CR_REPEAT 14
`define CR_CH0 13
`define CR_EXT_REF 2
`define CR_PSLEEP 0

// ********************
// result word fields
// ********************
`define TAG_HI 15
`define TAG_LO 12
`define RES_HI 11
`define RES_LO 2

`endif

// [common/adc_ctrl_pkg.sv]
// types shared by the converter control design
`default_nettype none

package adc_ctrl_pkg;
	typedef enum {PWR_BOOT, PWR_RUN, PWR_OFF} power_state_t;
	typedef logic [15:0] frame_word_t;
	typedef logic [2:0] chan_t;
	typedef logic [7:0] chan_mask_t;
	typedef logic [9:0] result_t;
endpackage : adc_ctrl_pkg

`default_nettype wire

// [rtl/sleep_pin_timer.sv]
// low-width timer for the combined sleep/clear pin
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module sleep_pin_timer import adc_ctrl_pkg::*; #(
	parameter int unsigned SHORT_CYC = `PIN_PULSE_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// pin
	input wire logic sleep_clear_n_in,
	// decoded events
	output logic clear_out,
	output logic sleep_out
);
	localparam int unsigned CW = $clog2(SHORT_CYC + 2);
	localparam logic [CW-1:0] SHORT_W = CW'(SHORT_CYC);

	logic sync1_q;
	logic sync2_q;
	logic [CW-1:0] low_cnt_q;
	logic clear_q;
	logic sleep_q;

	// ********************
	// pin synchroniser
	// ********************
	// the pin is asynchronous; lows shorter than one clock may be missed
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= sleep_clear_n_in;
			sync2_q <= sync1_q;
		end
	end

	// ********************
	// low width
	// ********************
	// saturates one past the short limit, enough to tell the two cases apart
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || sync2_q) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q <= SHORT_W) begin
			low_cnt_q <= low_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sleep_q <= 1'b0;
			clear_q <= 1'b0;
		end else begin
			sleep_q <= !sync2_q && (low_cnt_q > SHORT_W);
			clear_q <= sync2_q && (low_cnt_q != '0) && (low_cnt_q <= SHORT_W);
		end
	end

	assign clear_out = clear_q;
	assign sleep_out = sleep_q;
endmodule : sleep_pin_timer

`default_nettype wire

// [rtl/adc_serial_power_control.sv]
// serial transfer, sequencer and power control of the eight-channel converter
// How it works
// - pin low over 100 ns: full sleep
// - full sleep wipes control and internal registers
// - pin back high starts wake-up
// - power-on reset zeroes the control register
// - interface usable 500 us after power-up
// - short low pulse resets control register, sequence and output word
// - select fall: sample, convert, drive output
// - fourteenth falling edge returns to tracking
// - output floats at sixteenth edge or select
// - early select rise aborts, keeps control
// - word: four tag bits, ten-bit result
// - first bit at select, rest per fall
// - write control word only when flagged
// - serial clock also times the conversion
// - internal reference usable 6 ms after power-up, external reference at once
// - result appears one transfer later
// - enabled channels converted in ascending order
// - all ones when sequence done or empty
// - partial sleep sends all ones
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_serial_power_control import adc_ctrl_pkg::*; #(
	parameter int unsigned READY_CYC = `IFACE_READY_CYC,
	parameter int unsigned WAKE_CYC = `WAKE_CYC,
	parameter int unsigned REF_CYC = `REF_SETTLE_CYC
) (
	// system clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// sleep/clear pin
	input wire logic sleep_clear_n_in,
	// serial link
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	output logic dout_out,
	output logic dout_oe_out,
	// analog core
	output logic hold_out,
	output logic [2:0] conv_channel_out,
	output logic conv_valid_out,
	input wire logic [9:0] conv_result_in,
	// status and configuration
	output logic ready_out,
	output logic ref_ready_out,
	output logic full_sleep_out,
	output logic partial_sleep_bit_out,
	output logic ext_ref_sel_out
);
	localparam int unsigned WAIT_MAX = (READY_CYC > WAKE_CYC) ? READY_CYC : WAKE_CYC;
	localparam int unsigned WW = $clog2(WAIT_MAX + 1);
	localparam int unsigned RW = $clog2(REF_CYC + 1);
	localparam logic [4:0] CNT_END = 5'(`FRAME_BITS);
	localparam logic [4:0] CNT_LAST = 5'(`FRAME_LAST);
	localparam logic [4:0] CNT_TRACK = 5'(`TRACK_EDGE);

	// ********************
	// helpers
	// ********************
	function automatic chan_mask_t field_mask(input frame_word_t w);
		chan_mask_t m;
		m = '0;
		for (int i = 0; i < `NUM_CHANS; i++) begin
			m[i] = w[`CR_CH0 - i];
		end
		return m;
	endfunction : field_mask

	function automatic chan_t lowest_chan(input chan_mask_t m);
		chan_t c;
		c = '0;
		for (int i = `NUM_CHANS - 1; i >= 0; i--) begin
			if (m[i]) begin
				c = chan_t'(i);
			end
		end
		return c;
	endfunction : lowest_chan

	function automatic chan_mask_t chan_bit(input chan_t c);
		return chan_mask_t'(1) << c;
	endfunction : chan_bit

	// ********************
	// link domain (serial clock)
	// ********************
	logic [4:0] cnt_q;
	frame_word_t rx_q;
	result_t res_q;
	logic done_tgl_q;
	logic link_rst_q;
	frame_word_t tx_word_q;
	logic [3:0] bit_idx;

	// cleared while select is high so every frame starts at zero
	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_END) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(negedge sclk_in) begin
		if (!cs_n_in && cnt_q != CNT_END) begin
			rx_q <= {rx_q[`FRAME_LAST-1:0], din_in};
		end
	end

	// result is complete by the last edge of the frame
	always_ff @(negedge sclk_in) begin
		if (!cs_n_in && cnt_q == CNT_LAST) begin
			res_q <= conv_result_in;
		end
	end

	// only full frames reach the system side
	always_ff @(negedge sclk_in or posedge link_rst_q) begin
		if (link_rst_q) begin
			done_tgl_q <= 1'b0;
		end else if (!cs_n_in && cnt_q == CNT_LAST) begin
			done_tgl_q <= ~done_tgl_q;
		end
	end

	assign bit_idx = 4'(CNT_LAST - cnt_q);
	assign dout_oe_out = !cs_n_in && (cnt_q != CNT_END);
	assign dout_out = tx_word_q[bit_idx];
	assign hold_out = !cs_n_in && (cnt_q < CNT_TRACK);

	// ********************
	// sleep pin and crossing
	// ********************
	logic pin_clear;
	logic pin_sleep;
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic frame_done;

	sleep_pin_timer #(
		.SHORT_CYC(`PIN_PULSE_CYC)
	) u_pin (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.sleep_clear_n_in(sleep_clear_n_in),
		.clear_out(pin_clear),
		.sleep_out(pin_sleep)
	);

	always_ff @(posedge clk_in) begin
		link_rst_q <= !rst_n_in || pin_sleep;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= done_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign frame_done = tgl_s2_q ^ tgl_s3_q;

	// ********************
	// power state
	// ********************
	power_state_t state_q;
	logic [WW-1:0] wait_q;
	logic [RW-1:0] ref_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= PWR_BOOT;
			wait_q <= WW'(READY_CYC);
		end else if (pin_sleep) begin
			state_q <= PWR_OFF;
			wait_q <= WW'(WAKE_CYC);
		end else begin
			case (state_q)
				PWR_OFF: begin
					state_q <= PWR_BOOT;
				end
				PWR_BOOT: begin
					if (wait_q == '0) begin
						state_q <= PWR_RUN;
					end else begin
						wait_q <= wait_q - 1'b1;
					end
				end
				PWR_RUN: begin
					state_q <= PWR_RUN;
				end
				default: begin
					state_q <= PWR_BOOT;
				end
			endcase
		end
	end

	// the internal reference restarts its settling after every power-up
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_q == PWR_OFF) begin
			ref_q <= RW'(REF_CYC);
		end else if (ref_q != '0) begin
			ref_q <= ref_q - 1'b1;
		end
	end

	// ********************
	// control register
	// ********************
	logic cfg_rst;
	logic take;
	logic wr;
	logic repeat_q;
	chan_mask_t ch_en_q;
	logic ext_ref_q;
	logic psleep_q;

	// words arriving before the interface is ready are dropped
	assign cfg_rst = !rst_n_in || pin_clear || pin_sleep || state_q == PWR_OFF;
	assign take = frame_done && (state_q == PWR_RUN);
	assign wr = take && rx_q[`CR_WRITE];

	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			repeat_q <= 1'b0;
			ch_en_q <= '0;
			ext_ref_q <= 1'b0;
			psleep_q <= 1'b0;
		end else if (wr) begin
			repeat_q <= rx_q[`CR_REPEAT];
			ch_en_q <= field_mask(rx_q);
			ext_ref_q <= rx_q[`CR_EXT_REF];
			psleep_q <= rx_q[`CR_PSLEEP];
		end
	end

	// ********************
	// sequencer
	// ********************
	chan_mask_t pend_q;
	chan_mask_t pend_d;
	chan_t cur_q;
	logic cur_valid_q;
	logic rep_now;
	logic psleep_now;

	always_comb begin
		pend_d = pend_q;
		rep_now = wr ? rx_q[`CR_REPEAT] : repeat_q;
		psleep_now = wr ? rx_q[`CR_PSLEEP] : psleep_q;
		if (wr) begin
			pend_d = field_mask(rx_q);
		end else if (take && cur_valid_q) begin
			pend_d = pend_q & ~chan_bit(cur_q);
			if (rep_now && pend_d == '0) begin
				pend_d = ch_en_q;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			pend_q <= '0;
			cur_q <= '0;
			cur_valid_q <= 1'b0;
		end else if (take) begin
			pend_q <= pend_d;
			cur_q <= lowest_chan(pend_d);
			cur_valid_q <= (pend_d != '0) && !psleep_now;
		end
	end

	// ********************
	// outgoing word
	// ********************
	// the word for the next frame is built from the conversion just finished
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			tx_word_q <= '1;
		end else if (take) begin
			if (cur_valid_q && !psleep_now) begin
				tx_word_q <= '0;
				tx_word_q[`TAG_HI:`TAG_LO] <= {1'b0, cur_q};
				tx_word_q[`RES_HI:`RES_LO] <= res_q;
			end else begin
				tx_word_q <= '1;
			end
		end
	end

	// ********************
	// status
	// ********************
	assign conv_channel_out = cur_q;
	assign conv_valid_out = cur_valid_q;
	assign ready_out = (state_q == PWR_RUN);
	assign full_sleep_out = (state_q == PWR_OFF);
	assign partial_sleep_bit_out = psleep_q;
	assign ext_ref_sel_out = ext_ref_q;
	assign ref_ready_out = ext_ref_q || (ref_q == '0);
endmodule : adc_serial_power_control

`default_nettype wire

// [tb/serial_host_model.sv]
// serial host that frames transfers on the converter link
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out,
	input wire logic dout_in
);
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end

	// sclk stands high between frames; fewer than 16 falls aborts the frame
	task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'hffff;
		cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			din_out = w[15 - i];
			#16;
			r[15 - i] = dout_in;
			sclk_out = 1'b0;
			#16;
			sclk_out = 1'b1;
		end
		#8;
		cs_n_out = 1'b1;
		din_out = ~din_out;
		// gap above 80 ns lets the system side settle; odd value keeps off clock edges
		#97;
	endtask : frame
endmodule : serial_host_model

`default_nettype wire

// [tb/adc_serial_power_control_sva.sv]
// checker for the converter control ports
`timescale 1ns/10ps
`default_nettype none

module adc_serial_power_control_sva (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sleep_clear_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic dout_oe_out,
	input wire logic hold_out,
	input wire logic ready_out,
	input wire logic ref_ready_out,
	input wire logic full_sleep_out,
	input wire logic partial_sleep_bit_out,
	input wire logic ext_ref_sel_out
);
	logic [4:0] falls_q;

	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			falls_q <= 5'h0;
		end else if (falls_q != 5'h10) begin
			falls_q <= falls_q + 5'h1;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// ********************
	// pin pulses
	// ********************
	sequence short_low;
		sleep_clear_n_in ##1 !sleep_clear_n_in [*5] ##1 sleep_clear_n_in;
	endsequence
	sequence long_low;
		!sleep_clear_n_in [*8] ##1 !sleep_clear_n_in [*8];
	endsequence

	a_frame_drive: assert property (!cs_n_in && falls_q < 5'he |-> dout_oe_out && hold_out)
		else $error("output or hold missing in frame");
	a_track_return: assert property (cs_n_in || falls_q >= 5'he |-> !hold_out)
		else $error("hold past fourteenth fall");
	a_frame_float: assert property (cs_n_in || falls_q == 5'h10 |-> !dout_oe_out)
		else $error("output driven outside frame");
	a_reset_defaults: assert property ($rose(rst_n_in) |->
		!ready_out && !partial_sleep_bit_out && !ext_ref_sel_out)
		else $error("config not zero after reset");
	a_sleep_wipes: assert property (full_sleep_out |->
		!ready_out && !partial_sleep_bit_out && !ext_ref_sel_out)
		else $error("state kept in full sleep");
	a_long_sleep: assert property (long_low |-> ##[0:6] full_sleep_out)
		else $error("long low did not sleep");
	a_short_clear: assert property (short_low |->
		!full_sleep_out [*8] ##0 (!partial_sleep_bit_out && !ext_ref_sel_out))
		else $error("short pulse misread");
	a_pin_wake: assert property (sleep_clear_n_in [*8] |-> !full_sleep_out)
		else $error("sleep kept with pin high");
	a_ext_ref: assert property ($rose(ext_ref_sel_out) |-> ##[0:2] ref_ready_out)
		else $error("external ref not ready");
	a_ref_restart: assert property ($fell(full_sleep_out) |-> !ref_ready_out)
		else $error("internal ref settle not restarted");
endmodule : adc_serial_power_control_sva

bind adc_serial_power_control adc_serial_power_control_sva chk (.clk_in, .rst_n_in,
	.sleep_clear_n_in, .sclk_in, .cs_n_in, .dout_oe_out, .hold_out, .ready_out,
	.ref_ready_out, .full_sleep_out, .partial_sleep_bit_out, .ext_ref_sel_out);

`default_nettype wire

// [tb/tb_adc_serial_power_control.sv]
// testbench: power control and serial frames of the converter control
`timescale 1ns/10ps
`default_nettype none

module tb_adc_serial_power_control;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sleep_clear_n_in = 1'b1;
	logic [9:0] conv_result_in = 10'h0;
	logic [15:0] rd;
	int err_count = 0;
	int n_checks = 0;
	wire logic sclk, cs_n, din, dout, dout_oe, hold, cvalid, ready, ref_rdy, fsl, psl, ext;
	wire logic [2:0] chan;

	always #5 clk_in = ~clk_in;

	adc_serial_power_control #(.READY_CYC(20), .WAKE_CYC(5), .REF_CYC(30)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .sleep_clear_n_in(sleep_clear_n_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
		.dout_oe_out(dout_oe), .hold_out(hold), .conv_channel_out(chan),
		.conv_valid_out(cvalid), .conv_result_in(conv_result_in), .ready_out(ready),
		.ref_ready_out(ref_rdy), .full_sleep_out(fsl), .partial_sleep_bit_out(psl),
		.ext_ref_sel_out(ext));

	serial_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic wait_ready(input logic lvl);
		for (int i = 0; ready !== lvl; i++) begin
			if (i > 200) begin
				err_count++;
				report_and_stop();
			end
			@(posedge clk_in);
			#1;
		end
	endtask : wait_ready

	task automatic pin_low(input int n);
		@(posedge clk_in);
		sleep_clear_n_in <= 1'b0;
		repeat (n) @(posedge clk_in);
		sleep_clear_n_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		#1;
	endtask : pin_low

	// ********************
	// scenarios
	// ********************
	task automatic t_reset();
		#1;
		chk({13'h0, ready, psl, ext}, 16'h0);
		wait_ready(1'b1);
		$display("reset test done");
	endtask : t_reset

	task automatic t_sequence();
		host.frame(16'h9404, 16, rd);
		chk(rd, 16'hffff);
		chk({13'h0, cvalid, chan}, 16'h9);
		@(posedge clk_in) conv_result_in <= 10'h2a5;
		host.frame(16'h0, 16, rd);
		chk(rd, 16'hffff);
		chk({13'h0, cvalid, chan}, 16'hb);
		@(posedge clk_in) conv_result_in <= 10'h15a;
		host.frame(16'h0, 16, rd);
		chk(rd, {4'h1, 10'h2a5, 2'h0});
		chk({15'h0, cvalid}, 16'h0);
		host.frame(16'h0, 16, rd);
		chk(rd, {4'h3, 10'h15a, 2'h0});
		host.frame(16'h0, 16, rd);
		chk(rd, 16'hffff);
		chk({14'h0, ext, ref_rdy}, 16'h3);
		$display("sequence test done");
	endtask : t_sequence

	task automatic t_abort();
		host.frame(16'h8001, 8, rd);
		chk({14'h0, psl, ext}, 16'h1);
		// channel 0 pending, so the partial sleep frame converts a real channel
		host.frame(16'ha000, 16, rd);
		chk(rd, 16'hffff);
		host.frame(16'h8001, 16, rd);
		chk({14'h0, psl, ext}, 16'h2);
		host.frame(16'h0, 16, rd);
		chk(rd, 16'hffff);
		$display("abort test done");
	endtask : t_abort

	task automatic t_clear();
		pin_low(5);
		chk({13'h0, fsl, psl, ready}, 16'h1);
		$display("clear test done");
	endtask : t_clear

	task automatic t_sleep();
		host.frame(16'h8004, 16, rd);
		@(posedge clk_in) sleep_clear_n_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		#1;
		chk({13'h0, fsl, ready, ext}, 16'h4);
		@(posedge clk_in) sleep_clear_n_in <= 1'b1;
		wait_ready(1'b1);
		#1;
		chk({14'h0, fsl, ext}, 16'h0);
		host.frame(16'h0, 16, rd);
		chk(rd, 16'hffff);
		$display("sleep test done");
	endtask : t_sleep

	task automatic t_repeat();
		host.frame(16'hd000, 16, rd);
		chk(rd, 16'hffff);
		@(posedge clk_in) conv_result_in <= 10'h0c3;
		host.frame(16'h0, 16, rd);
		chk(rd, 16'hffff);
		host.frame(16'h0, 16, rd);
		chk(rd, {4'h1, 10'h0c3, 2'h0});
		host.frame(16'h0, 16, rd);
		chk(rd, {4'h1, 10'h0c3, 2'h0});
		$display("repeat test done");
	endtask : t_repeat

	initial begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_sequence();
		t_abort();
		t_clear();
		t_sleep();
		t_repeat();
		report_and_stop();
	end
endmodule : tb_adc_serial_power_control

`default_nettype wire
